// file: hdl/eebb_pkg.sv
// Constants shared by the serial EEPROM control port and its array engine.
package eebb_pkg;
    // Register placement in data memory.
    localparam logic [7:0] PORT_ADDR     = 8'h40;
    localparam logic       PORT_BANK     = 1'h1;
    localparam logic [7:0] PORT_RESET    = 8'h00;
    // Field positions inside the port register.
    localparam int         BIT_SELECT    = 4;
    localparam int         BIT_CLOCK     = 5;
    localparam int         BIT_SER_IN    = 6;
    localparam int         BIT_SER_OUT   = 7;
    // Instruction codes sent after the start bit.
    localparam logic [1:0] OP_SPECIAL    = 2'h0;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_ERASE      = 2'h3;
    // Sub-codes carried in the two leading address bits of a special instruction.
    localparam logic [1:0] SUB_LOCK      = 2'h0;
    localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
    localparam logic [1:0] SUB_UNLOCK    = 2'h3;
    localparam logic [7:0] ERASED_BYTE   = 8'hff;
    // Array defaults.
    localparam int         ARRAY_DEPTH   = 128;
    localparam int         WRITE_CYCLES  = 400;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_OPCODE   = 3'b001,
        ST_ADDRESS  = 3'b010,
        ST_DATA_IN  = 3'b011,
        ST_READ_OUT = 3'b100,
        ST_WAIT_END = 3'b101,
        ST_BUSY     = 3'b110
    } eebb_state_type;
endpackage

// file: hdl/eebb_wire_if.sv
// Four-wire bus (select, clock, data in, data out with its output enable) between the control port and the EEPROM array.
`timescale 1ns/10ps
interface eebb_wire_if;
    logic select;
    logic shift_clock_bit;
    logic serial_in_bit;
    logic ser_out;
    logic ser_out_oe;
    modport ctrl (output select, output shift_clock_bit, output serial_in_bit, input ser_out, input ser_out_oe);
    modport mem  (input select, input shift_clock_bit, input serial_in_bit, output ser_out, output ser_out_oe);
endinterface

// file: hdl/eebb_array.sv
// Serial EEPROM array with instruction decoder and internal write timer.
`timescale 1ns/10ps
module eebb_array #(
    parameter int DEPTH  = eebb_pkg::ARRAY_DEPTH,
    parameter int WCYCLE = eebb_pkg::WRITE_CYCLES
) (
    // Clock, reset and enable
    input wire logic     clk_sys,
    input wire logic     rst,
    input wire logic     clk_en,
    // Serial bus
    eebb_wire_if.mem     wi
);
    localparam int AB = (DEPTH > 128) ? 9 : 7;
    localparam int IW = $clog2(DEPTH);

    eebb_pkg::eebb_state_type state_q, state_d;
    logic [7:0]  arr_q [DEPTH];
    logic [7:0]  arr_d [DEPTH];
    logic [1:0]  op_q, op_d;
    logic [8:0]  addr_q, addr_d;
    logic [8:0]  sh_q, sh_d;
    logic [7:0]  data_q, data_d;
    logic [7:0]  rsh_q, rsh_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [15:0] timer_q, timer_d;
    logic        en_q, en_d;
    logic        status_q, status_d;
    logic        skp_q, skp_d;
    logic        do_q, do_d;
    logic        oe_q, oe_d;
    logic        sclk_rise;
    logic [8:0]  addr_new;

    function automatic logic [IW-1:0] idx(input logic [8:0] a);
        idx = a[IW-1:0];
    endfunction

    assign sclk_rise   = wi.shift_clock_bit & ~skp_q;
    assign addr_new    = {sh_q[7:0], wi.serial_in_bit};
    assign wi.ser_out    = do_q;
    assign wi.ser_out_oe = oe_q;

    always_comb begin
        state_d  = state_q;
        arr_d    = arr_q;
        op_d     = op_q;
        addr_d   = addr_q;
        sh_d     = sh_q;
        data_d   = data_q;
        rsh_d    = rsh_q;
        cnt_d    = cnt_q;
        timer_d  = timer_q;
        en_d     = en_q;
        status_d = status_q;
        do_d     = do_q;
        oe_d     = oe_q;
        skp_d    = wi.shift_clock_bit;
        if (state_q == eebb_pkg::ST_BUSY) begin
            // Serial output reads low while the write cycle runs, high when done.
            oe_d = wi.select; // see RL17
            do_d = 1'b0;
            timer_d = timer_q - 16'h0001;
            if (timer_q == 16'h0000) begin
                do_d     = 1'b1;
                status_d = 1'b1;
                state_d  = eebb_pkg::ST_IDLE;
                if (op_q == eebb_pkg::OP_WRITE) begin
                    arr_d[idx(addr_q)] = data_q;
                end else if (op_q == eebb_pkg::OP_ERASE) begin
                    arr_d[idx(addr_q)] = eebb_pkg::ERASED_BYTE;
                end else begin
                    for (int i = 0; i < DEPTH; i++) begin
                        arr_d[i] = (addr_q[AB-1:AB-2] == eebb_pkg::SUB_WRITE_ALL) ? data_q : eebb_pkg::ERASED_BYTE;
                    end
                end
            end
        end else if (!wi.select) begin
            // Output floats outside a read or a status poll; dropping select ends the command.
            oe_d    = 1'b0; // see RL7
            state_d = eebb_pkg::ST_IDLE; // see RL9
            if (state_q == eebb_pkg::ST_WAIT_END) begin
                if (op_q == eebb_pkg::OP_SPECIAL && addr_q[AB-1:AB-2] == eebb_pkg::SUB_UNLOCK) begin
                    en_d = 1'b1; // see RL18
                end else if (op_q == eebb_pkg::OP_SPECIAL && addr_q[AB-1:AB-2] == eebb_pkg::SUB_LOCK) begin
                    en_d = 1'b0; // see RL18
                end else if (en_q) begin
                    state_d = eebb_pkg::ST_BUSY; // see RL18
                    timer_d = 16'(WCYCLE - 1);
                end
            end
        end else begin
            if (state_q == eebb_pkg::ST_IDLE) begin
                oe_d = status_q;
                do_d = 1'b1;
            end
            if (sclk_rise) begin
                // Bits are taken on the rising edge with data already stable.
                case (state_q) // see RL8
                    eebb_pkg::ST_IDLE: begin
                        if (wi.serial_in_bit) begin
                            state_d  = eebb_pkg::ST_OPCODE; // see RL15
                            status_d = 1'b0;
                            oe_d     = 1'b0;
                            cnt_d    = 4'h0;
                        end
                    end
                    eebb_pkg::ST_OPCODE: begin
                        op_d  = {op_q[0], wi.serial_in_bit};
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == 4'h1) begin
                            state_d = eebb_pkg::ST_ADDRESS;
                            cnt_d   = 4'h0;
                        end
                    end
                    eebb_pkg::ST_ADDRESS: begin
                        sh_d  = addr_new;
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == 4'(AB - 1)) begin
                            addr_d  = addr_new;
                            cnt_d   = 4'h0;
                            state_d = eebb_pkg::ST_WAIT_END;
                            if (op_q == eebb_pkg::OP_READ) begin
                                state_d = eebb_pkg::ST_READ_OUT;
                                do_d    = 1'b0; // see RL16
                                oe_d    = 1'b1;
                                rsh_d   = arr_q[idx(addr_new)];
                            end else if (op_q == eebb_pkg::OP_WRITE ||
                                         (op_q == eebb_pkg::OP_SPECIAL &&
                                          addr_new[AB-1:AB-2] == eebb_pkg::SUB_WRITE_ALL)) begin
                                state_d = eebb_pkg::ST_DATA_IN;
                            end
                        end
                    end
                    eebb_pkg::ST_DATA_IN: begin
                        data_d = {data_q[6:0], wi.serial_in_bit};
                        cnt_d  = cnt_q + 4'h1;
                        if (cnt_q == 4'h7) begin
                            state_d = eebb_pkg::ST_WAIT_END;
                        end
                    end
                    eebb_pkg::ST_READ_OUT: begin
                        // Most significant bit first, then the next byte follows without a gap.
                        do_d = rsh_q[7]; // see RL6
                        if (cnt_q == 4'h7) begin
                            addr_d = addr_q + 9'h001; // see RL16
                            rsh_d  = arr_q[idx(addr_q + 9'h001)];
                            cnt_d  = 4'h0;
                        end else begin
                            rsh_d = {rsh_q[6:0], 1'b0};
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                    default: begin
                        state_d = state_q;
                    end
                endcase
            end
        end
    end

    // The array contents start erased; real cells would keep data across reset.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q  <= eebb_pkg::ST_IDLE;
            for (int i = 0; i < DEPTH; i++) begin
                arr_q[i] <= eebb_pkg::ERASED_BYTE; // see RL13
            end
            op_q     <= 2'h0;
            addr_q   <= 9'h000;
            sh_q     <= 9'h000;
            data_q   <= 8'h00;
            rsh_q    <= 8'h00;
            cnt_q    <= 4'h0;
            timer_q  <= 16'h0000;
            en_q     <= 1'b0;
            status_q <= 1'b0;
            skp_q    <= 1'b0;
            do_q     <= 1'b0;
            oe_q     <= 1'b0;
        end else if (clk_en) begin
            state_q  <= state_d;
            arr_q    <= arr_d;
            op_q     <= op_d;
            addr_q   <= addr_d;
            sh_q     <= sh_d;
            data_q   <= data_d;
            rsh_q    <= rsh_d;
            cnt_q    <= cnt_d;
            timer_q  <= timer_d;
            en_q     <= en_d;
            status_q <= status_d;
            skp_q    <= skp_d;
            do_q     <= do_d;
            oe_q     <= oe_d;
        end
    end

    sequence s_busy_hold;
        state_q == eebb_pkg::ST_BUSY [*8];
    endsequence

    chk_read_dummy: assert property (@(posedge clk_sys) disable iff (rst) // see RL16
        (clk_en && wi.select && sclk_rise && state_q == eebb_pkg::ST_ADDRESS && op_q == eebb_pkg::OP_READ &&
         cnt_q == 4'(AB - 1)) |=> (oe_q && !do_q))
        else $error("read did not start with a driven zero");
    chk_read_shift: assert property (@(posedge clk_sys) disable iff (rst) // see RL6
        (clk_en && wi.select && sclk_rise && state_q == eebb_pkg::ST_READ_OUT) |=> (do_q == $past(rsh_q[7])))
        else $error("read bit not presented on the clock edge");
    chk_float_idle: assert property (@(posedge clk_sys) disable iff (rst) // see RL7
        (clk_en && !wi.select && state_q != eebb_pkg::ST_BUSY) |=> !oe_q)
        else $error("serial output driven without select");
    chk_busy_low: assert property (@(posedge clk_sys) disable iff (rst) // see RL17
        (clk_en && wi.select && state_q == eebb_pkg::ST_BUSY && timer_q != 16'h0000) |=> (oe_q && !do_q))
        else $error("serial output not low during write cycle");
    chk_busy_span: assert property (@(posedge clk_sys) disable iff (rst) // see RL17
        $rose(state_q == eebb_pkg::ST_BUSY) |-> s_busy_hold)
        else $error("write cycle ended too early");
    chk_locked_write: assert property (@(posedge clk_sys) disable iff (rst) // see RL18
        (clk_en && !wi.select && !en_q && state_q == eebb_pkg::ST_WAIT_END && op_q != eebb_pkg::OP_SPECIAL)
        |=> state_q == eebb_pkg::ST_IDLE)
        else $error("locked array accepted a write");
endmodule

// file: hdl/eebb_port.sv
// Control port register that bit-bangs the internal serial EEPROM.
`timescale 1ns/10ps
// Overview of operation
// RL1: Register bit 4 drives the EEPROM select line.
// RL2: Register bit 5 drives the EEPROM serial clock.
// RL3: Register bit 6 drives the EEPROM serial input line.
// RL4: Register bit 7 reads back the EEPROM serial output line.
// RL5: Register bits 0 to 3 always read zero.
// RL6: On reads the EEPROM presents each bit on a rising serial clock.
// RL7: Serial output floats except while a read or a status poll is running.
// RL8: Software sets the input bit first, then raises the clock.
// RL9: Software clears select after the last bit to end the transfer.
// RL10: The register decodes only at location 40H in bank 1.
// RL11: Only the second indirect path reaches the register, never direct addressing.
// RL12: Software loads the second pointer with 40H and bank 1 first.
// RL13: The array holds 128 or 256 bytes depending on variant.
// RL14: Software runs the initialisation procedure after power-on.
// RL15: Instructions start with a 1, then a two-bit opcode.
// RL16: Reads give a dummy zero, MSB first, then auto-increment and stream.
// RL17: After write or erase the output stays low until done, then high.
// RL18: Write and erase are refused until unlocked; unlock lasts until locked.
// RL19: Writes to the output bit and low bits have no effect.
module eebb_port #(
    parameter int DEPTH  = eebb_pkg::ARRAY_DEPTH,
    parameter int WCYCLE = eebb_pkg::WRITE_CYCLES
) (
    // Clock, reset and enable
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // Data memory access from the core
    input  wire logic       acc_valid,
    input  wire logic       acc_write,
    input  wire logic       acc_indirect1,
    input  wire logic       acc_bank,
    input  wire logic [7:0] acc_addr,
    input  wire logic [7:0] acc_wdata,
    // Access answer
    output logic            acc_hit_q,
    output logic [7:0]      acc_rdata_q
);
    eebb_wire_if wi ();

    logic       sel_q, sel_d;
    logic       skc_q, skc_d;
    logic       sin_q, sin_d;
    logic       hit_d;
    logic [7:0] rdata_d;
    logic       hit;
    logic       out_bit;

    // Direct accesses never match, so the port cannot be hit by a stray direct write.
    assign hit     = acc_valid && acc_indirect1 && (acc_bank == eebb_pkg::PORT_BANK) &&
                     (acc_addr == eebb_pkg::PORT_ADDR); // see RL10 see RL11
    // A floating output reads as zero; software only samples it during reads or polls.
    assign out_bit = wi.ser_out_oe & wi.ser_out; // see RL4

    assign wi.select          = sel_q; // see RL1
    assign wi.shift_clock_bit = skc_q; // see RL2
    assign wi.serial_in_bit   = sin_q; // see RL3

    always_comb begin
        sel_d   = sel_q;
        skc_d   = skc_q;
        sin_d   = sin_q;
        rdata_d = acc_rdata_q;
        hit_d   = hit;
        if (hit && acc_write) begin
            // Only the three driven lines store; output and low bits are dropped.
            sel_d = acc_wdata[eebb_pkg::BIT_SELECT]; // see RL1 see RL19
            skc_d = acc_wdata[eebb_pkg::BIT_CLOCK]; // see RL2
            sin_d = acc_wdata[eebb_pkg::BIT_SER_IN]; // see RL3
        end else if (hit) begin
            rdata_d = {out_bit, sin_q, skc_q, sel_q, 4'h0}; // see RL4 see RL5
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_q       <= eebb_pkg::PORT_RESET[eebb_pkg::BIT_SELECT];
            skc_q       <= eebb_pkg::PORT_RESET[eebb_pkg::BIT_CLOCK];
            sin_q       <= eebb_pkg::PORT_RESET[eebb_pkg::BIT_SER_IN];
            acc_rdata_q <= eebb_pkg::PORT_RESET;
            acc_hit_q   <= 1'b0;
        end else if (clk_en) begin
            sel_q       <= sel_d;
            skc_q       <= skc_d;
            sin_q       <= sin_d;
            acc_rdata_q <= rdata_d;
            acc_hit_q   <= hit_d;
        end
    end

    // The serial engine samples the clock bit on the same clock, so no synchroniser is needed.
    eebb_array #(
        .DEPTH  (DEPTH),
        .WCYCLE (WCYCLE)
    ) u_array (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clk_en  (clk_en),
        .wi      (wi)
    );

    chk_select_drive: assert property (@(posedge clk_sys) disable iff (rst) // see RL1
        (clk_en && hit && acc_write) |=> (wi.select == $past(acc_wdata[eebb_pkg::BIT_SELECT])))
        else $error("select line does not follow bit 4");
    chk_clock_drive: assert property (@(posedge clk_sys) disable iff (rst) // see RL2
        (clk_en && hit && acc_write) |=> (wi.shift_clock_bit == $past(acc_wdata[eebb_pkg::BIT_CLOCK])))
        else $error("serial clock does not follow bit 5");
    chk_input_drive: assert property (@(posedge clk_sys) disable iff (rst) // see RL3
        (clk_en && hit && acc_write) |=> (wi.serial_in_bit == $past(acc_wdata[eebb_pkg::BIT_SER_IN])))
        else $error("serial input does not follow bit 6");
    chk_output_read: assert property (@(posedge clk_sys) disable iff (rst) // see RL4
        (clk_en && hit && !acc_write) |=> (acc_rdata_q[7] == $past(out_bit)))
        else $error("bit 7 does not return serial output");
    chk_low_zero: assert property (@(posedge clk_sys) disable iff (rst) // see RL5
        acc_rdata_q[3:0] == 4'h0)
        else $error("unimplemented bits read nonzero");
    chk_direct_miss: assert property (@(posedge clk_sys) disable iff (rst) // see RL11
        (clk_en && acc_valid && !acc_indirect1 && acc_write) |=> $stable(wi.select) && !acc_hit_q)
        else $error("direct access reached the port");
    chk_bank_decode: assert property (@(posedge clk_sys) disable iff (rst) // see RL10
        (clk_en && acc_valid && (acc_bank != eebb_pkg::PORT_BANK || acc_addr != eebb_pkg::PORT_ADDR))
        |=> !acc_hit_q)
        else $error("port answered outside its location");
endmodule

// file: testbench/eebb_core_model.sv
// Core-side model that issues data-memory accesses to the control port.
`timescale 1ns/10ps
module eebb_core_model (
    // Clock
    input  wire logic       clk_sys,
    // Access request
    output logic            acc_valid,
    output logic            acc_write,
    output logic            acc_indirect1,
    output logic            acc_bank,
    output logic [7:0]      acc_addr,
    output logic [7:0]      acc_wdata,
    // Access answer
    input  wire logic       acc_hit_q,
    input  wire logic [7:0] acc_rdata_q
);
    initial begin
        acc_valid     = 1'b0;
        acc_write     = 1'b0;
        acc_indirect1 = 1'b0;
        acc_bank      = 1'b0;
        acc_addr      = 8'h00;
        acc_wdata     = 8'h00;
    end

    // One strobe per access; the qualifiers are inverted on release so stale values never look valid.
    task automatic access(input logic ind, input logic bank, input logic [7:0] addr, input logic wr,
                          input logic [7:0] wdata, output logic hit, output logic [7:0] rdata);
        @(posedge clk_sys);
        #2;
        acc_valid     = 1'b1;
        acc_write     = wr;
        acc_indirect1 = ind;
        acc_bank      = bank;
        acc_addr      = addr;
        acc_wdata     = wdata;
        @(posedge clk_sys);
        #2;
        hit           = acc_hit_q;
        rdata         = acc_rdata_q;
        acc_valid     = 1'b0;
        acc_write     = ~wr;
        acc_indirect1 = ~ind;
        acc_bank      = ~bank;
        acc_addr      = ~addr;
        acc_wdata     = ~wdata;
    endtask
endmodule

// file: testbench/tb_eeprom_bitbang_control_port.sv
// Self-checking bench that bit-bangs the serial EEPROM through the control port.
`timescale 1ns/10ps
module tb_eeprom_bitbang_control_port;
    localparam int WCYCLE_TB = 10;
    logic       clk_sys;
    logic       rst;
    logic       clk_en;
    logic       acc_valid;
    logic       acc_write;
    logic       acc_indirect1;
    logic       acc_bank;
    logic [7:0] acc_addr;
    logic [7:0] acc_wdata;
    logic       acc_hit_q;
    logic [7:0] acc_rdata_q;
    logic [7:0] v;
    int         bad_count;
    int         checked;

    always #12.5 clk_sys = ~clk_sys;

    eebb_port #(.DEPTH(128), .WCYCLE(WCYCLE_TB)) dut (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_indirect1(acc_indirect1), .acc_bank(acc_bank), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_hit_q(acc_hit_q), .acc_rdata_q(acc_rdata_q));

    eebb_core_model core (
        .clk_sys(clk_sys), .acc_valid(acc_valid), .acc_write(acc_write), .acc_indirect1(acc_indirect1),
        .acc_bank(acc_bank), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_hit_q(acc_hit_q),
        .acc_rdata_q(acc_rdata_q));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("Counts: %0d compared, %0d mismatched", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic port_acc(input logic ind, input logic bank, input logic [7:0] addr, input logic wr,
                            input logic [7:0] wd, input logic exp_hit, output logic [7:0] rd);
        logic hit;
        core.access(ind, bank, addr, wr, wd, hit, rd);
        chk("access hit", {7'h00, hit}, {7'h00, exp_hit});
    endtask

    task automatic port_wr(input logic [7:0] wd);
        logic [7:0] rd;
        port_acc(1'b1, eebb_pkg::PORT_BANK, eebb_pkg::PORT_ADDR, 1'b1, wd, 1'b1, rd);
    endtask

    task automatic port_rd(output logic [7:0] rd);
        port_acc(1'b1, eebb_pkg::PORT_BANK, eebb_pkg::PORT_ADDR, 1'b0, 8'h00, 1'b1, rd);
    endtask

    // The data bit is set with the clock low, then the clock is raised with the bit held.
    task automatic send_bit(input logic b);
        port_wr({1'b0, b, 1'b0, 1'b1, 4'h0});
        port_wr({1'b0, b, 1'b1, 1'b1, 4'h0});
    endtask

    task automatic send_cmd(input logic [1:0] op, input logic [6:0] addr);
        port_wr(8'h10);
        send_bit(1'b1);
        for (int i = 1; i >= 0; i--) send_bit(op[i]);
        for (int i = 6; i >= 0; i--) send_bit(addr[i]);
    endtask

    task automatic send_byte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) send_bit(d[i]);
    endtask

    // Select low starts any write cycle; the fixed wait covers the whole internal write time.
    task automatic end_op();
        port_wr(8'h00);
        repeat (WCYCLE_TB + 10) @(posedge clk_sys);
    endtask

    task automatic get_byte(output logic [7:0] d);
        logic [7:0] r;
        for (int i = 7; i >= 0; i--) begin
            send_bit(1'b0);
            port_rd(r);
            d[i] = r[7];
        end
    endtask

    task automatic read_chk(input logic [6:0] addr, input logic [7:0] exp0, input logic [7:0] exp1);
        logic [7:0] r;
        send_cmd(eebb_pkg::OP_READ, addr);
        port_rd(r);
        chk("dummy bit and control bits", r, {1'b0, addr[0], 2'b11, 4'h0});
        get_byte(r);
        chk("first byte", r, exp0);
        get_byte(r);
        chk("streamed byte", r, exp1);
        end_op();
    endtask

    initial begin
        #500000;
        bad_count++;
        complete_run();
    end

    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        clk_en = 1'b1;
        bad_count = 0;
        checked = 0;
        repeat (4) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        port_rd(v);
        chk("reset value", v, eebb_pkg::PORT_RESET);
        port_wr(8'hff);
        port_rd(v);
        chk("writable bits", v, 8'h70);
        end_op();
        $display("test register bits done");
        port_acc(1'b0, 1'b1, 8'h40, 1'b1, 8'h10, 1'b0, v);
        port_acc(1'b1, 1'b0, 8'h40, 1'b1, 8'h10, 1'b0, v);
        port_acc(1'b1, 1'b1, 8'h41, 1'b1, 8'h10, 1'b0, v);
        port_rd(v);
        chk("refused writes", v, 8'h00);
        $display("test decode done");
        send_cmd(eebb_pkg::OP_WRITE, 7'h05);
        send_byte(8'h3c);
        end_op();
        read_chk(7'h05, 8'hff, 8'hff);
        $display("test locked write done");
        send_cmd(eebb_pkg::OP_SPECIAL, {eebb_pkg::SUB_UNLOCK, 5'h00});
        end_op();
        send_cmd(eebb_pkg::OP_WRITE, 7'h7f);
        send_byte(8'hc3);
        port_wr(8'h00);
        port_wr(8'h10);
        port_rd(v);
        chk("busy status", v, 8'h10);
        repeat (WCYCLE_TB + 5) @(posedge clk_sys);
        port_rd(v);
        chk("ready status", v, 8'h90);
        end_op();
        send_cmd(eebb_pkg::OP_WRITE, 7'h00);
        send_byte(8'h81);
        end_op();
        read_chk(7'h7f, 8'hc3, 8'h81);
        port_rd(v);
        chk("output floats", v, 8'h00);
        $display("test write and wrap done");
        send_cmd(eebb_pkg::OP_ERASE, 7'h7f);
        end_op();
        read_chk(7'h7f, eebb_pkg::ERASED_BYTE, 8'h81);
        send_cmd(eebb_pkg::OP_SPECIAL, {eebb_pkg::SUB_WRITE_ALL, 5'h00});
        send_byte(8'h5a);
        end_op();
        read_chk(7'h21, 8'h5a, 8'h5a);
        send_cmd(eebb_pkg::OP_SPECIAL, {eebb_pkg::SUB_LOCK, 5'h00});
        end_op();
        send_cmd(eebb_pkg::OP_SPECIAL, {eebb_pkg::SUB_ERASE_ALL, 5'h00});
        end_op();
        read_chk(7'h21, 8'h5a, 8'h5a);
        $display("test erase and lock done");
        // A write offered while the enable is low must leave the port untouched.
        #2;
        clk_en = 1'b0;
        port_acc(1'b1, 1'b1, 8'h40, 1'b1, 8'h10, 1'b0, v);
        clk_en = 1'b1;
        port_rd(v);
        chk("frozen write", v, 8'h00);
        $display("test clock enable done");
        complete_run();
    end
endmodule
